// >>> inc/cfv_pkg.sv
// Constants and types shared by the flag, stack and vector logic
package cfv_pkg;
	// I/O locations of the core registers
	localparam logic [5:0] IO_SP_LOW = 6'h3d;
	localparam logic [5:0] IO_SP_HIGH = 6'h3e;
	localparam logic [5:0] IO_FLAGS = 6'h3f;
	// Flag bit positions
	localparam int FLAG_I = 7;
	localparam int FLAG_T = 6;
	localparam int FLAG_H = 5;
	localparam int FLAG_S = 4;
	localparam int FLAG_V = 3;
	localparam int FLAG_N = 2;
	localparam int FLAG_Z = 1;
	localparam int FLAG_C = 0;
	// Positions in the ALU update select
	localparam int SEL_H = 4;
	localparam int SEL_V = 3;
	localparam int SEL_N = 2;
	localparam int SEL_Z = 1;
	localparam int SEL_C = 0;
	// Reset values
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [15:0] SP_RESET = 16'h0000;
	localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
	// Vector table
	localparam int NUM_IRQ = 12;
	localparam int IRQ_IDX_W = 4;
	localparam int PC_W = 12;
	localparam logic [11:0] VEC_RESET = 12'h000;
	localparam logic [11:0] VEC_FIRST_IRQ = 12'h001;
	// Stack adjustments
	localparam logic [15:0] SP_STEP_BYTE = 16'h0001;
	localparam logic [15:0] SP_STEP_ADDR = 16'h0002;
	// Interrupt entry sequencer
	typedef enum logic [2:0] {
		ST_BOOT,
		ST_IDLE,
		ST_PUSH_LO,
		ST_PUSH_HI,
		ST_VECTOR
	} cfv_state_t;
endpackage : cfv_pkg

// >>> inc/cfv_arb_if.sv
// Request and grant bundle between the core and the priority picker
`timescale 1ns/1ps
interface cfv_arb_if;
	logic [cfv_pkg::NUM_IRQ-1:0] req;
	logic grant_valid;
	logic [cfv_pkg::IRQ_IDX_W-1:0] grant_idx;
	modport picker (input req, output grant_valid, output grant_idx);
	modport core (output req, input grant_valid, input grant_idx);
endinterface : cfv_arb_if

// >>> verilog/cfv_arbiter.sv
// Fixed priority picker: lowest source index wins
`timescale 1ns/1ps
module cfv_arbiter (
	cfv_arb_if.picker arb
);
	import cfv_pkg::*;

	// Scan from the highest index down so the lowest set index is left
	always_comb begin
		arb.grant_valid = 1'b0;
		arb.grant_idx = '0;
		for (int i = NUM_IRQ - 1; i >= 0; i--) begin
			if (arb.req[i]) begin
				arb.grant_valid = 1'b1; // RULE18
				arb.grant_idx = IRQ_IDX_W'(i);
			end
		end
	end
endmodule : cfv_arbiter

// >>> verilog/cfv_core.sv
// Flag register, stack pointer and interrupt vectoring of the processor core
// Notes on behaviour
// RULE1: Bit 7 of the flags is the global interrupt enable; needed for any interrupt.
// RULE2: With global enable clear, no interrupt is taken regardless of source enables.
// RULE3: Taking an interrupt clears global enable; interrupt return sets it again.
// RULE4: Bit 6 is a one-bit store written by bit-store, read by bit-load.
// RULE5: Bit 5 records low-nibble carry from operations that define it.
// RULE6: Bit 4 always equals negative flag xor overflow flag.
// RULE7: Bit 3 shows two's complement overflow of signed arithmetic.
// RULE8: Bit 2 is set on a negative result, cleared otherwise.
// RULE9: Bit 1 is set on an all-zero result, cleared otherwise.
// RULE10: Bit 0 holds the carry of an arithmetic or logic operation.
// RULE11: Flags are neither saved on interrupt entry nor restored on return.
// RULE12: Stack pointer is 16 bits, high byte at 3e, low byte at 3d, read/write.
// RULE13: Software loads the stack pointer above 60 before calls or enabling interrupts.
// RULE14: Stack pointer drops one per pushed byte, rises one per popped byte.
// RULE15: Stack pointer drops two per pushed return address, rises two on return.
// RULE16: Twelve interrupt sources plus reset, each with a vector at the lowest addresses.
// RULE17: A source is serviced only with its own enable and global enable set.
// RULE18: Lowest vector address wins among pending requests; reset highest, then request 0.
// RULE19: After any reset, execution starts at program address zero.
// RULE20: Sources map to vectors 001 to 00c in the fixed table order.
// RULE21: Vectoring to a handler clears the flag of the source taken.
// RULE22: Requests raised with global enable clear stay pending until it is set.
// RULE23: Interrupt entry pushes the two-byte return address, then loads the vector.
`timescale 1ns/1ps
module cfv_core (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic [5:0] io_addr,
	input wire logic io_we,
	input wire logic io_re,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	input wire logic alu_update,
	input wire logic [4:0] alu_flag_sel,
	input wire logic [7:0] alu_result,
	input wire logic alu_carry,
	input wire logic alu_half,
	input wire logic alu_ovf,
	input wire logic bit_store_op,
	input wire logic bit_store_val,
	output logic bit_load_val,
	input wire logic set_gie,
	input wire logic clr_gie,
	input wire logic push_byte,
	input wire logic pop_byte,
	input wire logic call_push,
	input wire logic return_from_call,
	input wire logic return_from_irq,
	input wire logic irq_boundary,
	input wire logic [cfv_pkg::PC_W-1:0] ret_pc,
	input wire logic [cfv_pkg::NUM_IRQ-1:0] irq_req,
	input wire logic [cfv_pkg::NUM_IRQ-1:0] irq_enable,
	input wire logic [cfv_pkg::NUM_IRQ-1:0] irq_flag_clear,
	output logic [7:0] cpu_flags,
	output logic [15:0] stack_pointer,
	output logic [cfv_pkg::NUM_IRQ-1:0] irq_pending,
	output logic stk_we,
	output logic [15:0] stk_addr,
	output logic [7:0] stk_wdata,
	output logic pc_load,
	output logic [cfv_pkg::PC_W-1:0] pc_vector,
	output logic core_hold
);
	import cfv_pkg::*;

	// Add or subtract a step from the stack pointer
	function automatic logic [15:0] sp_adj(input logic [15:0] sp, input logic [15:0] step,
		input logic down);
		sp_adj = down ? sp - step : sp + step;
	endfunction : sp_adj

	logic rst_meta_q;
	logic rst_n;
	logic [7:0] flags_q, flags_d;
	logic [15:0] sp_q, sp_d;
	logic [NUM_IRQ-1:0] pend_q, pend_d;
	cfv_state_t state_q, state_d;
	logic [IRQ_IDX_W-1:0] idx_q, idx_d;
	logic [PC_W-1:0] rpc_q, rpc_d;
	logic [7:0] rdata_q, rdata_d;
	logic stk_we_q, stk_we_d;
	logic [15:0] stk_addr_q, stk_addr_d;
	logic [7:0] stk_wdata_q, stk_wdata_d;
	logic pc_load_q, pc_load_d;
	logic [PC_W-1:0] pc_vec_q, pc_vec_d;
	logic hold_q, hold_d;
	logic take;
	logic n_new, v_new;
	cfv_arb_if arb ();

	// Reset release through two flip-flops
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	// Only enabled and globally permitted sources compete
	assign arb.req = flags_q[FLAG_I] ? (pend_q & irq_enable) : '0; // RULE1 RULE2 RULE17
	cfv_arbiter u_arbiter (
		.arb(arb.picker)
	);
	assign take = (state_q == ST_IDLE) && irq_boundary && arb.grant_valid;

	// Pending flags: a new request wins over any clear in the same cycle
	always_comb begin
		pend_d = pend_q & ~irq_flag_clear; // RULE22
		if (take) begin
			pend_d[arb.grant_idx] = 1'b0; // RULE21
		end
		pend_d = pend_d | irq_req;
	end

	// Flag register next value
	always_comb begin
		flags_d = flags_q;
		if (io_we && io_addr == IO_FLAGS) begin
			flags_d = io_wdata;
		end else if (alu_update) begin
			if (alu_flag_sel[SEL_H]) flags_d[FLAG_H] = alu_half; // RULE5
			if (alu_flag_sel[SEL_V]) flags_d[FLAG_V] = alu_ovf; // RULE7
			if (alu_flag_sel[SEL_N]) flags_d[FLAG_N] = alu_result[7]; // RULE8
			if (alu_flag_sel[SEL_Z]) flags_d[FLAG_Z] = (alu_result == 8'h00); // RULE9
			if (alu_flag_sel[SEL_C]) flags_d[FLAG_C] = alu_carry; // RULE10
		end
		if (bit_store_op) begin
			flags_d[FLAG_T] = bit_store_val; // RULE4
		end
		if (set_gie || (return_from_irq && state_q == ST_IDLE)) begin
			flags_d[FLAG_I] = 1'b1; // RULE3
		end
		if (clr_gie || take) begin
			flags_d[FLAG_I] = 1'b0; // RULE3
		end
		// Sign bit is never stored independently
		n_new = flags_d[FLAG_N];
		v_new = flags_d[FLAG_V];
		flags_d[FLAG_S] = n_new ^ v_new; // RULE6
	end

	// Stack pointer next value; entry pushes own the pointer while busy
	always_comb begin
		sp_d = sp_q;
		if (state_q == ST_PUSH_LO || state_q == ST_PUSH_HI) begin
			sp_d = sp_adj(sp_q, SP_STEP_BYTE, 1'b1); // RULE14 RULE23
		end else if (io_we && io_addr == IO_SP_LOW) begin
			sp_d = {sp_q[15:8], io_wdata}; // RULE12
		end else if (io_we && io_addr == IO_SP_HIGH) begin
			sp_d = {io_wdata, sp_q[7:0]}; // RULE12
		end else if (push_byte) begin
			sp_d = sp_adj(sp_q, SP_STEP_BYTE, 1'b1); // RULE14
		end else if (pop_byte) begin
			sp_d = sp_adj(sp_q, SP_STEP_BYTE, 1'b0); // RULE14
		end else if (call_push) begin
			sp_d = sp_adj(sp_q, SP_STEP_ADDR, 1'b1); // RULE15
		end else if (return_from_call || return_from_irq) begin
			sp_d = sp_adj(sp_q, SP_STEP_ADDR, 1'b0); // RULE15 RULE11
		end
	end

	// Register read port, answered one cycle after the strobe
	always_comb begin
		rdata_d = rdata_q;
		if (io_re) begin
			unique case (io_addr)
				IO_FLAGS: rdata_d = flags_q;
				IO_SP_HIGH: rdata_d = sp_q[15:8];
				IO_SP_LOW: rdata_d = sp_q[7:0];
				default: rdata_d = RDATA_UNMAPPED;
			endcase
		end
	end

	// Boot and interrupt entry sequencer
	always_comb begin
		state_d = state_q;
		idx_d = idx_q;
		rpc_d = rpc_q;
		stk_we_d = 1'b0;
		stk_addr_d = stk_addr_q;
		stk_wdata_d = stk_wdata_q;
		pc_load_d = 1'b0;
		pc_vec_d = pc_vec_q;
		unique case (state_q)
			ST_BOOT: begin
				pc_load_d = 1'b1;
				pc_vec_d = VEC_RESET; // RULE19
				state_d = ST_IDLE;
			end
			ST_IDLE: begin
				if (take) begin
					idx_d = arb.grant_idx;
					rpc_d = ret_pc;
					state_d = ST_PUSH_LO;
				end
			end
			ST_PUSH_LO: begin
				stk_we_d = 1'b1;
				stk_addr_d = sp_q;
				stk_wdata_d = rpc_q[7:0]; // RULE23
				state_d = ST_PUSH_HI;
			end
			ST_PUSH_HI: begin
				stk_we_d = 1'b1;
				stk_addr_d = sp_q;
				stk_wdata_d = 8'(rpc_q[PC_W-1:8]); // RULE23
				state_d = ST_VECTOR;
			end
			ST_VECTOR: begin
				pc_load_d = 1'b1;
				pc_vec_d = VEC_FIRST_IRQ + PC_W'(idx_q); // RULE16 RULE20
				state_d = ST_IDLE;
			end
		endcase
		hold_d = (state_d != ST_IDLE);
	end

	// State registers, frozen while the clock enable is low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_q <= FLAGS_RESET;
			sp_q <= SP_RESET;
			pend_q <= '0;
			state_q <= ST_BOOT;
			idx_q <= '0;
			rpc_q <= '0;
			rdata_q <= RDATA_UNMAPPED;
			stk_we_q <= 1'b0;
			stk_addr_q <= 16'h0000;
			stk_wdata_q <= 8'h00;
			pc_load_q <= 1'b0;
			pc_vec_q <= VEC_RESET;
			hold_q <= 1'b1;
		end else if (clk_en) begin
			flags_q <= flags_d;
			sp_q <= sp_d;
			pend_q <= pend_d;
			state_q <= state_d;
			idx_q <= idx_d;
			rpc_q <= rpc_d;
			rdata_q <= rdata_d;
			stk_we_q <= stk_we_d;
			stk_addr_q <= stk_addr_d;
			stk_wdata_q <= stk_wdata_d;
			pc_load_q <= pc_load_d;
			pc_vec_q <= pc_vec_d;
			hold_q <= hold_d;
		end
	end

	// Outputs straight from flip-flops
	assign io_rdata = rdata_q;
	assign cpu_flags = flags_q;
	assign bit_load_val = flags_q[FLAG_T]; // RULE4
	assign stack_pointer = sp_q;
	assign irq_pending = pend_q;
	assign stk_we = stk_we_q;
	assign stk_addr = stk_addr_q;
	assign stk_wdata = stk_wdata_q;
	assign pc_load = pc_load_q;
	assign pc_vector = pc_vec_q;
	assign core_hold = hold_q;

	// Checks on the guarded behaviour
	gie_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
		take |-> flags_q[FLAG_I])
		else $error("interrupt taken with global enable clear");
	gie_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
		(take && clk_en && !set_gie) |=> !flags_q[FLAG_I])
		else $error("global enable not cleared on entry");
	return_from_irq_set_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
		(clk_en && return_from_irq && state_q == ST_IDLE && !clr_gie && !take)
		|=> flags_q[FLAG_I])
		else $error("interrupt return did not set global enable");
	sign_bit_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
		cpu_flags[FLAG_S] == (cpu_flags[FLAG_N] ^ cpu_flags[FLAG_V]))
		else $error("sign bit differs from negative xor overflow");
	zero_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
		(clk_en && alu_update && alu_flag_sel[SEL_Z] && !(io_we && io_addr == IO_FLAGS))
		|=> cpu_flags[FLAG_Z] == ($past(alu_result) == 8'h00))
		else $error("zero flag does not match result");
	push_step_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
		(clk_en && push_byte && !io_we && state_q == ST_IDLE)
		|=> stack_pointer == $past(stack_pointer) - 16'h0001)
		else $error("byte push did not drop pointer by one");
	ret_step_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
		(clk_en && return_from_call && !io_we && !push_byte && !pop_byte && !call_push
		&& state_q == ST_IDLE) |=> stack_pointer == $past(stack_pointer) + 16'h0002)
		else $error("return did not raise pointer by two");
	prio_low_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE18
		take |-> ((arb.req & ((12'h001 << arb.grant_idx) - 12'h001)) == 12'h000))
		else $error("lower numbered request was passed over");
	flag_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE21
		(take && clk_en && !irq_req[arb.grant_idx]) |=> !pend_q[$past(arb.grant_idx)])
		else $error("taken source flag not cleared");
	entry_seq_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE23
		(take && clk_en) ##1 clk_en ##1 clk_en ##1 clk_en
		|-> (stk_we && $past(stk_we) && (stk_addr == $past(stk_addr) - 16'h0001))
		##1 (pc_load && pc_vector == VEC_FIRST_IRQ + PC_W'(idx_q)))
		else $error("entry push and vector sequence broken");
endmodule : cfv_core

// >>> bench/cfv_pipe_model.sv
// Pipeline side model: boundary offer, stack memory and vector capture
`timescale 1ns/1ps
module cfv_pipe_model (
	input wire logic clk,
	input wire logic core_hold,
	input wire logic stk_we,
	input wire logic [15:0] stk_addr,
	input wire logic [7:0] stk_wdata,
	input wire logic pc_load,
	input wire logic [11:0] pc_vector,
	output logic irq_boundary
);
	// Small stack window; addresses alias above 511
	logic [7:0] mem [512];
	logic [11:0] vec = 12'hfff;
	initial irq_boundary = 1'b0;
	// Offer an instruction boundary one cycle after each cycle in which the core hold is low
	always @(posedge clk) begin
		irq_boundary <= !core_hold;
	end
	// Stack bytes and vector loads as the pipeline would see them
	always @(posedge clk) begin
		if (stk_we) mem[stk_addr[8:0]] <= stk_wdata;
		if (pc_load) vec <= pc_vector;
	end
endmodule : cfv_pipe_model

// >>> bench/cpu_flags_stack_and_vectors_tb_top.sv
// Self-checking bench for flags, stack pointer and interrupt entry
`timescale 1ns/1ps
module cpu_flags_stack_and_vectors_tb_top;
	import cfv_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic io_we = 1'b0;
	logic io_re = 1'b0;
	logic bsv = 1'b0;
	logic ce = 1'b1;
	logic cg = 1'b0;
	logic [2:0] cho = 3'h0;
	logic [5:0] io_addr = 6'h00;
	logic [7:0] io_wdata = 8'h00;
	logic [7:0] st = 8'h00;
	logic [4:0] sel = 5'h00;
	logic [7:0] res = 8'h00;
	logic [11:0] ret = 12'h000;
	logic [11:0] req = 12'h000;
	logic [11:0] en = 12'h000;
	logic [11:0] clr = 12'h000;
	logic [7:0] io_rdata, cpu_flags, stk_wdata;
	logic [15:0] stack_pointer, stk_addr;
	logic [11:0] irq_pending, pc_vector;
	logic bit_load_val, stk_we, pc_load, core_hold, irq_boundary;
	int n_errors = 0;
	int check_count = 0;

	cfv_core dut (.clk(clk), .resetn(resetn), .clk_en(ce), .io_addr(io_addr),
		.io_we(io_we), .io_re(io_re), .io_wdata(io_wdata), .io_rdata(io_rdata),
		.alu_update(st[7]), .alu_flag_sel(sel), .alu_result(res), .alu_carry(cho[2]),
		.alu_half(cho[1]), .alu_ovf(cho[0]), .bit_store_op(st[6]), .bit_store_val(bsv),
		.bit_load_val(bit_load_val), .set_gie(st[5]), .clr_gie(cg), .push_byte(st[0]),
		.pop_byte(st[1]), .call_push(st[2]), .return_from_call(st[3]),
		.return_from_irq(st[4]), .irq_boundary(irq_boundary), .ret_pc(ret),
		.irq_req(req), .irq_enable(en), .irq_flag_clear(clr), .cpu_flags(cpu_flags),
		.stack_pointer(stack_pointer), .irq_pending(irq_pending), .stk_we(stk_we),
		.stk_addr(stk_addr), .stk_wdata(stk_wdata), .pc_load(pc_load),
		.pc_vector(pc_vector), .core_hold(core_hold));
	cfv_pipe_model pm (.clk(clk), .core_hold(core_hold), .stk_we(stk_we),
		.stk_addr(stk_addr), .stk_wdata(stk_wdata), .pc_load(pc_load),
		.pc_vector(pc_vector), .irq_boundary(irq_boundary));

	// Clock at 125 MHz
	initial begin
		forever #4 clk = ~clk;
	end

	task chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	// One-cycle strobe on a pipeline line
	task pulse(input int b);
		@(posedge clk) st[b] <= 1'b1;
		@(posedge clk) st <= 8'h00;
		#1;
	endtask : pulse

	task wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk) begin
			io_addr <= a;
			io_wdata <= d;
			io_we <= 1'b1;
		end
		@(posedge clk) io_we <= 1'b0;
		#1;
	endtask : wr

	task rd(input logic [5:0] a, input logic [7:0] e);
		@(posedge clk) begin
			io_addr <= a;
			io_re <= 1'b1;
		end
		@(posedge clk) io_re <= 1'b0;
		@(posedge clk) #1 chk(16'(io_rdata), 16'(e));
	endtask : rd

	task alu(input logic [4:0] s, input logic [7:0] r, input logic [2:0] c);
		@(posedge clk) begin
			sel <= s;
			res <= r;
			cho <= c;
			st[7] <= 1'b1;
		end
		@(posedge clk) st <= 8'h00;
		#1;
	endtask : alu

	// Wait, bounded, for the vector load and compare its target
	task take(input logic [11:0] v);
		int i;
		for (i = 0; i < 20 && pc_load !== 1'b1; i++) @(posedge clk) #1;
		chk(16'(pc_vector), 16'(v));
	endtask : take

	task t_reset;
		int i;
		for (i = 0; i < 20 && core_hold !== 1'b0; i++) @(posedge clk) #1;
		// The pipeline captures the boot vector one edge after the load pulse
		@(posedge clk) #1;
		chk(16'(pm.vec), 16'h0000);
		rd(IO_SP_LOW, 8'h00);
		rd(IO_SP_HIGH, 8'h00);
		rd(IO_FLAGS, FLAGS_RESET);
		rd(6'h3c, RDATA_UNMAPPED);
		$display("reset test done");
	endtask : t_reset

	task t_flags;
		wr(IO_FLAGS, 8'hff);
		chk(16'(cpu_flags), 16'h00ef);
		@(posedge clk) cg <= 1'b1;
		@(posedge clk) cg <= 1'b0;
		#1 chk(16'(cpu_flags), 16'h006f);
		wr(IO_FLAGS, 8'h00);
		alu(5'h1f, 8'h00, 3'b110);
		chk(16'(cpu_flags), 16'h0023);
		alu(5'h1f, 8'h80, 3'b001);
		chk(16'(cpu_flags), 16'h000c);
		alu(5'h01, 8'h00, 3'b100);
		chk(16'(cpu_flags), 16'h000d);
		@(posedge clk) bsv <= 1'b1;
		pulse(6);
		chk(16'({bit_load_val, cpu_flags}), 16'h014d);
		$display("flags test done");
	endtask : t_flags

	task t_stack;
		logic [15:0] e [4] = '{16'h00ff, 16'h0100, 16'h00fe, 16'h0100};
		int i;
		wr(IO_SP_HIGH, 8'h01);
		wr(IO_SP_LOW, 8'h00);
		chk(stack_pointer, 16'h0100);
		for (i = 0; i < 4; i++) begin
			pulse(i);
			chk(stack_pointer, e[i]);
		end
		// Clock enable low: a push strobe must leave the pointer alone
		@(posedge clk) ce <= 1'b0;
		pulse(0);
		chk(stack_pointer, 16'h0100);
		@(posedge clk) ce <= 1'b1;
		rd(IO_SP_HIGH, 8'h01);
		rd(6'h3c, RDATA_UNMAPPED);
		$display("stack test done");
	endtask : t_stack

	task t_prio;
		wr(IO_FLAGS, 8'h01);
		@(posedge clk) begin
			en <= 12'hffd;
			req <= 12'h02a;
		end
		@(posedge clk) req <= 12'h000;
		repeat (6) @(posedge clk);
		#1 chk(16'(irq_pending), 16'h002a);
		chk(16'(pm.vec), 16'h0000);
		pulse(5);
		take(12'h004);
		chk(16'(cpu_flags), 16'h0001);
		chk(16'(irq_pending), 16'h0022);
		pulse(4);
		take(12'h006);
		pulse(4);
		chk(16'(cpu_flags), 16'h0081);
		@(posedge clk) clr <= 12'h002;
		@(posedge clk) clr <= 12'h000;
		#1 chk(16'(irq_pending), 16'h0000);
		$display("priority test done");
	endtask : t_prio

	task t_vec;
		int i;
		@(posedge clk) en <= 12'hfff;
		for (i = 0; i < NUM_IRQ; i++) begin
			@(posedge clk) begin
				req <= 12'h001 << i;
				ret <= {i[3:0], 8'hc3};
			end
			@(posedge clk) req <= 12'h000;
			take(12'(i + 1));
			chk(16'(pm.mem[16'h0100]), 16'h00c3);
			chk(16'(pm.mem[16'h00ff]), 16'(i));
			chk(stack_pointer, 16'h00fe);
			chk(16'(cpu_flags[FLAG_I]), 16'h0000);
			pulse(4);
			chk(stack_pointer, 16'h0100);
		end
		$display("vector test done");
	endtask : t_vec

	task summarize;
		$display("checks %0d, mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : summarize

	// Cut a hang short well past the expected run time
	initial begin
		#200000;
		n_errors++;
		summarize();
	end

	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		t_reset();
		t_flags();
		t_stack();
		t_prio();
		t_vec();
		summarize();
	end
endmodule : cpu_flags_stack_and_vectors_tb_top
